// File: hw/msc_defs.svh
`ifndef MSC_DEFS_SVH
`define MSC_DEFS_SVH

// ----------------------------------------------------------------
// Word widths and field layout
// ----------------------------------------------------------------
`define MSC_SLOT_WORD_W 16
`define MSC_SLOT_LSB    0
`define MSC_SLOT_W      4
`define MSC_CHASSIS_LSB 4
`define MSC_CHASSIS_W   5
`define MSC_CFG_W       32
`define MSC_ID_W        32
`define MSC_PIN_W       4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MSC_CFG_RESET   32'h0000_0000
`define MSC_SLOT_RESET  16'h0000
`define MSC_CHASSIS_DEF 5'h00
`define MSC_PIN_IDLE    4'hc

`endif

// File: hw/msc_pkg.sv
package msc_pkg;

    // Serial pins from the acquisition controller
    typedef struct packed {
        logic sclk;
        logic strobe_n;
        logic dsel;
        logic sdi;
    } msc_pins_s;

    // Slot controller states, Gray along idle -> shift -> select
    typedef enum logic [1:0] {
        MSC_IDLE   = 2'b00,
        MSC_SHIFT  = 2'b01,
        MSC_SELECT = 2'b11
    } msc_slot_state_e;

endpackage : msc_pkg

// File: hw/msc_top.sv
`timescale 1ns/1ps
`include "msc_defs.svh"

module msc_top #(
    parameter int                          NUM_SLOTS    = 16,
    parameter int                          MODULE_SLOT  = 1,
    parameter bit                          ADDRESSABLE  = 1'b1,
    parameter logic [`MSC_CHASSIS_W-1:0]   CHASSIS_ADDR = `MSC_CHASSIS_DEF,
    // Arbitrary identification value
    parameter logic [`MSC_ID_W-1:0]        MODULE_ID    = 32'h5a3c_0f01
) (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst,
    // Serial link pins from the controller
    input  wire logic                      host_serial_data_in,
    input  wire logic                      data_address_select,
    input  wire logic                      slot_select_strobe_n,
    input  wire logic                      host_serial_clock,
    output logic                           host_serial_data_out,
    // Slot select lines, active low, one per slot
    output logic [NUM_SLOTS-1:0]           slot_select_n,
    // Module side
    output logic                           module_select_n,
    output logic [`MSC_CFG_W-1:0]          config_word
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Three flops per pin; a change counts only once stages two and
    // three agree, which also rejects a single-cycle glitch.
    logic [`MSC_PIN_W-1:0]  s1_reg;
    logic [`MSC_PIN_W-1:0]  s1_next;
    logic [`MSC_PIN_W-1:0]  s2_reg;
    logic [`MSC_PIN_W-1:0]  s2_next;
    logic [`MSC_PIN_W-1:0]  s3_reg;
    logic [`MSC_PIN_W-1:0]  s3_next;
    logic [`MSC_PIN_W-1:0]  filt_reg;
    logic [`MSC_PIN_W-1:0]  filt_next;
    logic [`MSC_PIN_W-1:0]  prev_reg;
    logic [`MSC_PIN_W-1:0]  prev_next;
    msc_pkg::msc_pins_s     pins_raw;
    msc_pkg::msc_pins_s     link;
    msc_pkg::msc_pins_s     link_prev;

    assign pins_raw.sclk     = host_serial_clock;
    assign pins_raw.strobe_n = slot_select_strobe_n;
    assign pins_raw.dsel     = data_address_select;
    assign pins_raw.sdi      = host_serial_data_in;

    always_comb begin
        s1_next   = pins_raw;
        s2_next   = s1_reg;
        s3_next   = s2_reg;
        prev_next = filt_reg;
    end

    genvar gi;
    generate
        for (gi = 0; gi < `MSC_PIN_W; gi++) begin : g_filt
            assign filt_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : filt_reg[gi];
        end
    endgenerate

    // Idle levels: clock high, strobe high, so no false edge after reset
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_reg   <= `MSC_PIN_IDLE;
            s2_reg   <= `MSC_PIN_IDLE;
            s3_reg   <= `MSC_PIN_IDLE;
            filt_reg <= `MSC_PIN_IDLE;
            prev_reg <= `MSC_PIN_IDLE;
        end else begin
            s1_reg   <= s1_next;
            s2_reg   <= s2_next;
            s3_reg   <= s3_next;
            filt_reg <= filt_next;
            prev_reg <= prev_next;
        end
    end

    assign link      = filt_reg;
    assign link_prev = prev_reg;

    // ----------------------------------------------------------------
    // Link edge detection
    // ----------------------------------------------------------------
    // Edges come from the filtered copies only, so every consumer below
    // sees data and clock with the same latency and in the same order.
    logic sclk_rise;
    logic sclk_fall;
    logic strobe_rise;

    assign sclk_rise   = link.sclk & ~link_prev.sclk;
    assign sclk_fall   = ~link.sclk & link_prev.sclk;
    assign strobe_rise = link.strobe_n & ~link_prev.strobe_n;

    // ----------------------------------------------------------------
    // Slot controller
    // ----------------------------------------------------------------
    msc_pkg::msc_slot_state_e     state_reg;
    msc_pkg::msc_slot_state_e     state_next;
    logic [`MSC_SLOT_WORD_W-1:0]  slot_word_reg;
    logic [`MSC_SLOT_WORD_W-1:0]  slot_word_next;
    logic [NUM_SLOTS-1:0]         sel_n_reg;
    logic [NUM_SLOTS-1:0]         sel_n_next;
    logic [NUM_SLOTS-1:0]         slot_hit;
    logic [`MSC_SLOT_W-1:0]       slot_field;
    logic [`MSC_CHASSIS_W-1:0]    chassis_field;
    logic                         chassis_match;
    logic                         slot_shift;

    assign slot_field    = slot_word_reg[`MSC_SLOT_LSB +: `MSC_SLOT_W];
    assign chassis_field = slot_word_reg[`MSC_CHASSIS_LSB +: `MSC_CHASSIS_W];
    // A non-addressable chassis ignores the chassis field entirely
    assign chassis_match = !ADDRESSABLE || (chassis_field == CHASSIS_ADDR);

    // Slot 0 is the controller itself and never gets a select line
    generate
        for (gi = 0; gi < NUM_SLOTS; gi++) begin : g_decode
            if (gi == 0) begin : g_self
                assign slot_hit[gi] = 1'b0;
            end else begin : g_mod
                assign slot_hit[gi] = chassis_match &&
                                      (slot_field == `MSC_SLOT_W'(gi));
            end
        end
    endgenerate

    always_comb begin
        state_next = state_reg;
        sel_n_next = sel_n_reg;
        case (state_reg)
            msc_pkg::MSC_IDLE: begin
                if (!link.strobe_n) begin
                    sel_n_next = '1;
                    state_next = msc_pkg::MSC_SHIFT;
                end
            end
            msc_pkg::MSC_SHIFT: begin
                sel_n_next = '1;
                if (strobe_rise) begin
                    sel_n_next = ~slot_hit;
                    state_next = msc_pkg::MSC_SELECT;
                end
            end
            msc_pkg::MSC_SELECT: begin
                if (!link.strobe_n) begin
                    sel_n_next = '1;
                    state_next = msc_pkg::MSC_SHIFT;
                end
            end
            default: begin
                sel_n_next = '1;
                state_next = msc_pkg::MSC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= msc_pkg::MSC_IDLE;
            sel_n_reg <= '1;
        end else begin
            state_reg <= state_next;
            sel_n_reg <= sel_n_next;
        end
    end

    // Slot word: a rise in the same cycle as the strobe rise is dropped,
    // because the decode has already taken the word as it stood.
    assign slot_shift = (state_reg == msc_pkg::MSC_SHIFT) && !strobe_rise && sclk_rise;

    always_comb begin
        slot_word_next = slot_word_reg;
        if (slot_shift) begin
            slot_word_next = {slot_word_reg[`MSC_SLOT_WORD_W-2:0], link.sdi};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            slot_word_reg <= `MSC_SLOT_RESET;
        end else begin
            slot_word_reg <= slot_word_next;
        end
    end

    // ----------------------------------------------------------------
    // Module select
    // ----------------------------------------------------------------
    // Everything below keys off this one registered line, so the
    // module never sees a half-decoded slot word.
    logic                   mod_selected;

    assign mod_selected = !sel_n_reg[MODULE_SLOT];

    // ----------------------------------------------------------------
    // Link arming
    // ----------------------------------------------------------------
    // A clock that is low when the module gets selected belongs to a bit
    // that began before selection; its rise must not reach the registers.
    logic                   armed_reg;
    logic                   armed_next;

    always_comb begin
        armed_next = armed_reg;
        if (!mod_selected) begin
            armed_next = 1'b0;
        end else if (link.sclk) begin
            armed_next = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            armed_reg <= 1'b0;
        end else begin
            armed_reg <= armed_next;
        end
    end

    // ----------------------------------------------------------------
    // Configuration shift register
    // ----------------------------------------------------------------
    logic [`MSC_CFG_W-1:0]  cfg_reg;
    logic [`MSC_CFG_W-1:0]  cfg_next;
    logic                   cfg_shift;

    // A low data/address select during a readout lands here too:
    // the register cannot tell a stray clock from a real write.
    assign cfg_shift = mod_selected && armed_reg && sclk_rise && !link.dsel;

    always_comb begin
        cfg_next = cfg_reg;
        if (cfg_shift) begin
            cfg_next = {cfg_reg[`MSC_CFG_W-2:0], link.sdi};
        end
    end

    // Not cleared on deselect: the last word written stays in force
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_reg <= `MSC_CFG_RESET;
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    // ----------------------------------------------------------------
    // Identification readout
    // ----------------------------------------------------------------
    localparam int ID_CNT_W = $clog2(`MSC_ID_W + 1);

    logic [`MSC_ID_W-1:0]   id_reg;
    logic [`MSC_ID_W-1:0]   id_next;
    logic [ID_CNT_W-1:0]    id_cnt_reg;
    logic [ID_CNT_W-1:0]    id_cnt_next;
    logic                   id_shift;
    logic                   id_spent;
    logic                   dout_reg;
    logic                   dout_next;

    assign id_shift = mod_selected && armed_reg && sclk_fall && link.dsel;
    // The counter, not the zero fill, decides when the word is used up,
    // so no fill pattern can leak past the last bit.
    assign id_spent = (id_cnt_reg == ID_CNT_W'(`MSC_ID_W));

    always_comb begin
        id_next     = id_reg;
        id_cnt_next = id_cnt_reg;
        dout_next   = dout_reg;
        if (!mod_selected) begin
            id_next     = MODULE_ID;
            id_cnt_next = '0;
            dout_next   = 1'b0;
        end else if (id_shift) begin
            if (id_spent) begin
                dout_next = 1'b0;
            end else begin
                dout_next   = id_reg[`MSC_ID_W-1];
                id_next     = {id_reg[`MSC_ID_W-2:0], 1'b0};
                id_cnt_next = id_cnt_reg + ID_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            id_reg     <= MODULE_ID;
            id_cnt_reg <= '0;
            dout_reg   <= 1'b0;
        end else begin
            id_reg     <= id_next;
            id_cnt_reg <= id_cnt_next;
            dout_reg   <= dout_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign host_serial_data_out = dout_reg;
    assign slot_select_n        = sel_n_reg;
    assign module_select_n      = sel_n_reg[MODULE_SLOT];
    assign config_word          = cfg_reg;

endmodule : msc_top

// File: sim/msc_top_properties.sv
`timescale 1ns/1ps
`include "msc_defs.svh"
module msc_top_checker #(
    parameter int NUM_SLOTS   = 16,
    parameter int MODULE_SLOT = 1
) (
    // Clock, reset and pins
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  host_serial_data_in,
    input wire logic                  data_address_select,
    input wire logic                  slot_select_strobe_n,
    input wire logic                  host_serial_clock,
    input wire logic                  host_serial_data_out,
    // Select lines and config
    input wire logic [NUM_SLOTS-1:0]  slot_select_n,
    input wire logic                  module_select_n,
    input wire logic [`MSC_CFG_W-1:0] config_word
);
    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_reset_idle: assert property (disable iff (1'b0) rst |=> (&slot_select_n) && module_select_n
        && config_word == '0 && !host_serial_data_out) else $error("outputs not idle after reset");
    a_module_follows: assert property (module_select_n == slot_select_n[MODULE_SLOT])
        else $error("module select differs from its slot line");
    a_slot_zero_off: assert property (slot_select_n[0]) else $error("slot zero selected");
    a_one_slot: assert property ($countones(~slot_select_n) <= 1) else $error("several slots selected");
    a_strobe_drop: assert property ($fell(slot_select_strobe_n) |-> ##[1:10] (&slot_select_n))
        else $error("strobe low did not drop selects");
    a_cfg_selected: assert property ($changed(config_word) |-> !$past(module_select_n))
        else $error("config changed while not selected");
    a_cfg_shift: assert property ($changed(config_word) |-> config_word[31:1] == $past(config_word[30:0]))
        else $error("config did not shift by one");
    a_dout_selected: assert property ($rose(host_serial_data_out) |-> !$past(module_select_n))
        else $error("data out rose while not selected");
endmodule : msc_top_checker

bind msc_top msc_top_checker #(.NUM_SLOTS(NUM_SLOTS), .MODULE_SLOT(MODULE_SLOT)) u_chk (.clk(clk), .rst(rst),
    .host_serial_data_in(host_serial_data_in), .data_address_select(data_address_select),
    .slot_select_strobe_n(slot_select_strobe_n), .host_serial_clock(host_serial_clock),
    .host_serial_data_out(host_serial_data_out), .slot_select_n(slot_select_n),
    .module_select_n(module_select_n), .config_word(config_word));

// File: sim/msc_host_model.sv
`timescale 1ns/1ps
module msc_host_model (
    // Clock and pins
    input  wire logic clk,
    input  wire logic host_serial_data_out,
    output logic      host_serial_data_in,
    output logic      data_address_select,
    output logic      slot_select_strobe_n,
    output logic      host_serial_clock
);
    // ------------------------------------------------
    // Controller side of the link
    // ------------------------------------------------
    initial begin
        host_serial_data_in  = 1'b0;
        data_address_select  = 1'b1;
        slot_select_strobe_n = 1'b1;
        host_serial_clock    = 1'b1;
    end
    task automatic half();
        repeat (4) @(negedge clk);
    endtask : half
    task automatic put_bit(input logic b);
        host_serial_data_in = b;
        host_serial_clock   = 1'b0;
        half();
        host_serial_clock = 1'b1;
        half();
    endtask : put_bit
    // Released data line shows the inverse so a stale level never reads as valid
    task automatic send(input logic [31:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) put_bit(w[i]);
        host_serial_data_in = ~host_serial_data_in;
        // The last rise needs several clocks to reach the registers
        half();
    endtask : send
    task automatic set_mode(input logic dsel);
        data_address_select = dsel;
    endtask : set_mode
    task automatic select(input logic [15:0] w, input logic dsel);
        data_address_select  = dsel;
        slot_select_strobe_n = 1'b0;
        half();
        send({16'h0, w}, 16);
        slot_select_strobe_n = 1'b1;
        repeat (10) @(negedge clk);
    endtask : select
    task automatic read_bit(output logic b);
        host_serial_clock = 1'b0;
        half();
        host_serial_clock = 1'b1;
        half();
        b = host_serial_data_out;
    endtask : read_bit
endmodule : msc_host_model

// File: sim/tb_msc_top.sv
`timescale 1ns/1ps
module tb_msc_top;
    localparam logic [31:0] ID = 32'hc3a5_0f96; // Arbitrary identification value
    logic        clk, rst, sdi, dsel, strobe_n, sclk, dout, msel_n, b;
    logic [15:0] sel_n, sel_n_any;
    logic [31:0] cfg;
    int          miscompares = 0;
    int          tests_run   = 0;
    int          cycles      = 0;
    // Slot word in the upper half, expected select lines in the lower
    logic [31:0] rows [6] = '{32'h0001_fffd, 32'h000b_f7ff, 32'hf001_fffd,
                              32'h000f_7fff, 32'h0121_ffff, 32'h0000_ffff};
    // Same words on a chassis that takes any chassis number
    logic [15:0] rows_any [6] = '{16'hfffd, 16'hf7ff, 16'hfffd, 16'h7fff, 16'hfffd, 16'hffff};
    // ------------------------------------------------
    // Clock, design and partner
    // ------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    msc_top #(.MODULE_ID(ID)) u_dut (.clk(clk), .rst(rst), .host_serial_data_in(sdi),
        .data_address_select(dsel), .slot_select_strobe_n(strobe_n), .host_serial_clock(sclk),
        .host_serial_data_out(dout), .slot_select_n(sel_n), .module_select_n(msel_n), .config_word(cfg));
    msc_top #(.ADDRESSABLE(1'b0), .MODULE_ID(ID)) u_dut_any (.clk(clk), .rst(rst), .host_serial_data_in(sdi),
        .data_address_select(dsel), .slot_select_strobe_n(strobe_n), .host_serial_clock(sclk),
        .host_serial_data_out(), .slot_select_n(sel_n_any), .module_select_n(), .config_word());
    msc_host_model u_host (.clk(clk), .host_serial_data_out(dout), .host_serial_data_in(sdi),
        .data_address_select(dsel), .slot_select_strobe_n(strobe_n), .host_serial_clock(sclk));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic summarize();
        $display("Checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize
    // Whole run needs about 2100 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
    end
    initial begin
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check("slot_select_n", {16'h0, sel_n}, 32'hffff);
        check("config_word", cfg, 32'h0);
        check("host_serial_data_out", {31'h0, dout}, 32'h0);
        $display("Test reset done");
        for (int i = 0; i < 6; i++) begin
            u_host.select(rows[i][31:16], 1'b1);
            check("slot_select_n", {16'h0, sel_n}, {16'h0, rows[i][15:0]});
            check("module_select_n", {31'h0, msel_n}, {31'h0, rows[i][1]});
            check("slot_select_n_any", {16'h0, sel_n_any}, {16'h0, rows_any[i]});
        end
        $display("Test slot table done");
        u_host.send(32'hffff_ffff, 32);
        check("config_word", cfg, 32'h0);
        u_host.select(16'h0001, 1'b0);
        u_host.send(32'h0150_11a7, 32);
        check("config_word", cfg, 32'h0150_11a7);
        $display("Test config write done");
        u_host.select(16'h0001, 1'b1);
        for (int k = 0; k < 34; k++) begin
            u_host.read_bit(b);
            check("id_bit", {31'h0, b}, {31'h0, (k < 32) ? ID[31-k] : 1'b0});
        end
        check("config_word", cfg, 32'h0150_11a7);
        u_host.select(16'h0001, 1'b1);
        u_host.read_bit(b);
        check("id_bit", {31'h0, b}, {31'h0, ID[31]});
        $display("Test id read done");
        @(negedge clk);
        u_host.set_mode(1'b0);
        u_host.send(32'h1, 1);
        check("config_word", cfg, 32'h02a0_234f);
        $display("Test read corruption done");
        summarize();
    end
endmodule : tb_msc_top
